// File: design/wfpf_filter.sv
// Operation
// R1 - Eight independent filter sets with five fields.
// R2 - Mask bits pick bytes counted from offset.
// R3 - CRC-16 0x8005 over masked bytes, compared stored.
// R4 - Match needs CRC and last byte equal.
// R5 - Offset counts two-byte steps from DA start.
// R6 - Last byte is highest set mask position.
// R7 - Cascaded CRC accumulates; final set verifies.
// R8 - Software loads cumulative precomputed CRC values.
// R9 - Command bit 0 enables the set.
// R10 - Command bit 1 requires station address.
// R11 - Command bit 2 requires multicast hash pass.
// R12 - Command bit 3 enables suspended auto reply.
// R13 - Cascade bit n joins set n+1 to n.
// R14 - Consecutive cascade bits chain many sets.
// R15 - Global bit 8: station address alone wakes.
// R16 - Global bit 9: hashed multicast alone wakes.
// R17 - Timer code masks host wake 0-28 s.
// R18 - Broadcast enable bit per filter set.
// R19 - Indexed word access, four bytes, LSB first.
// R20 - CRC preset ones, bits LSB first.
`default_nettype none
module wfpf_filter #(
  parameter int unsigned SEC_CYC = wfpf_pkg::SEC_CYCLES
) (
  input wire logic core_clk_in, // 250 MHz clock
  input wire logic rst_b_in, // synchronous reset, low
  input wire logic host_setup_valid_in, // setup stage strobe
  input wire logic host_setup_write_in, // setup is a write
  input wire logic [7:0] host_index_in, // array index
  input wire logic host_byte_valid_in, // data stage byte strobe
  input wire logic [7:0] host_byte_in, // data stage write byte
  output logic host_rd_valid_out, // read byte valid
  output logic [7:0] host_rd_byte_out, // read byte
  input wire logic rx_valid_in, // receive beat valid
  input wire wfpf_pkg::wfpf_rx_beat_t rx_beat_in, // receive beat
  input wire wfpf_pkg::wfpf_da_info_t rx_da_in, // MAC address checks
  input wire logic suspend_in, // suspend level, async
  output logic wake_frame_out, // wake frame seen pulse
  output logic wake_host_out, // unmasked wake pulse
  output logic [7:0] match_sets_out, // sets matched last frame
  output logic [7:0] reply_req_out, // auto reply request pulse
  output logic mask_active_out // host wake masked
);
  import wfpf_pkg::*;

  function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                            input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 0; b < 8; b++) begin
      if (r[0] ^ d[b]) begin
        r = (r >> 1) ^ CRC_POLY_REFL;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  function automatic wfpf_region_t region_of(input logic [7:0] idx);
    if (idx <= IDX_MASK_TOP) begin
      return WFPF_RG_MASK;
    end else if (idx < IDX_OFF_BASE) begin
      return WFPF_RG_CRC;
    end else if (idx < IDX_LAST_BASE) begin
      return WFPF_RG_OFF;
    end else if (idx < IDX_CMD) begin
      return WFPF_RG_LAST;
    end else if (idx == IDX_CMD) begin
      return WFPF_RG_CMD;
    end else begin
      return WFPF_RG_GLOB;
    end
  endfunction

  logic [31:0] mask_q [NUM_SETS];
  logic [15:0] crc_pat_q [NUM_SETS];
  logic [7:0] off_q [NUM_SETS];
  logic [7:0] last_pat_q [NUM_SETS];
  logic [3:0] cmd_q [NUM_SETS];
  logic [31:0] glob_q;

  // Indexed access engine.
  logic [7:0] idx_q;
  logic write_q;
  logic [2:0] bcnt_q;
  logic [23:0] wbuf_q;
  logic [31:0] rd_word_q;
  logic [31:0] rd_word_d;
  logic idx_ok;
  logic wr_commit;
  logic [31:0] wword;
  logic [7:0] idx_rel;

  assign idx_ok = (idx_q <= IDX_GLOBAL);
  assign wr_commit = host_byte_valid_in && !host_setup_valid_in && write_q
                     && (bcnt_q == 3'(BYTES_PER_WORD - 1)) && idx_ok;
  assign wword = {host_byte_in, wbuf_q}; // [R19]

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      idx_q <= 8'h00;
      write_q <= 1'b0;
      bcnt_q <= 3'(BYTES_PER_WORD);
      wbuf_q <= 24'h00_0000;
    end else if (host_setup_valid_in) begin
      idx_q <= host_index_in;
      write_q <= host_setup_write_in;
      bcnt_q <= 3'h0;
    end else if (host_byte_valid_in && bcnt_q < 3'(BYTES_PER_WORD)) begin
      if (bcnt_q < 3'(BYTES_PER_WORD - 1)) begin
        wbuf_q[bcnt_q[1:0]*8 +: 8] <= host_byte_in; // [R19]
      end
      bcnt_q <= bcnt_q + 3'h1;
    end
  end

  always_comb begin
    rd_word_d = 32'h0000_0000;
    idx_rel = 8'h00;
    if (host_index_in <= IDX_GLOBAL) begin
      case (region_of(host_index_in))
        WFPF_RG_MASK: begin
          rd_word_d = mask_q[host_index_in[2:0]];
        end
        WFPF_RG_CRC: begin
          idx_rel = host_index_in - IDX_CRC_BASE;
          rd_word_d = {crc_pat_q[{idx_rel[1:0], 1'b1}],
                       crc_pat_q[{idx_rel[1:0], 1'b0}]};
        end
        WFPF_RG_OFF: begin
          idx_rel = host_index_in - IDX_OFF_BASE;
          for (int j = 0; j < 4; j++) begin
            rd_word_d[j*8 +: 8] = off_q[{idx_rel[0], 2'(j)}];
          end
        end
        WFPF_RG_LAST: begin
          idx_rel = host_index_in - IDX_LAST_BASE;
          for (int j = 0; j < 4; j++) begin
            rd_word_d[j*8 +: 8] = last_pat_q[{idx_rel[0], 2'(j)}];
          end
        end
        WFPF_RG_CMD: begin
          for (int j = 0; j < NUM_SETS; j++) begin
            rd_word_d[j*4 +: 4] = cmd_q[j];
          end
        end
        default: begin
          rd_word_d = glob_q & GLB_RW_MASK;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      rd_word_q <= 32'h0000_0000;
      host_rd_valid_out <= 1'b0;
      host_rd_byte_out <= 8'h00;
    end else begin
      host_rd_valid_out <= 1'b0;
      if (host_setup_valid_in && !host_setup_write_in) begin
        rd_word_q <= rd_word_d;
      end else if (host_byte_valid_in && !write_q
                   && bcnt_q < 3'(BYTES_PER_WORD)) begin
        host_rd_valid_out <= 1'b1;
        host_rd_byte_out <= rd_word_q[bcnt_q[1:0]*8 +: 8]; // [R19]
      end
    end
  end

  // Filter array storage.
  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < NUM_SETS; i++) begin
        mask_q[i] <= 32'h0000_0000;
        crc_pat_q[i] <= 16'h0000;
        off_q[i] <= 8'h00;
        last_pat_q[i] <= 8'h00;
        cmd_q[i] <= 4'h0;
      end
      glob_q <= GLB_RESET;
    end else if (wr_commit) begin
      case (region_of(idx_q))
        WFPF_RG_MASK: begin
          mask_q[idx_q[2:0]] <= wword; // [R1] [R2]
        end
        WFPF_RG_CRC: begin
          crc_pat_q[{idx_q[1:0], 1'b0}] <= wword[15:0]; // [R8]
          crc_pat_q[{idx_q[1:0], 1'b1}] <= wword[31:16];
        end
        WFPF_RG_OFF: begin
          for (int j = 0; j < 4; j++) begin
            off_q[{idx_q[0], 2'(j)}] <= wword[j*8 +: 8];
          end
        end
        WFPF_RG_LAST: begin
          for (int j = 0; j < 4; j++) begin
            last_pat_q[{idx_q[0], 2'(j)}] <= wword[j*8 +: 8];
          end
        end
        WFPF_RG_CMD: begin
          for (int j = 0; j < NUM_SETS; j++) begin
            cmd_q[j] <= wword[j*4 +: 4];
          end
        end
        default: begin
          glob_q <= wword & GLB_RW_MASK;
        end
      endcase
    end
  end

  // Frame position and destination address classification.
  logic [POS_W-1:0] pos_q;
  logic [POS_W-1:0] cur_pos;
  logic da_bcast_q;
  logic da_mcast_q;
  logic eval_q;
  logic good_q;
  wfpf_da_info_t da_q;
  logic [NUM_SETS-2:0] casc;

  assign cur_pos = rx_beat_in.sof ? '0 : pos_q;
  assign casc = glob_q[GLB_CASC_LSB +: NUM_SETS-1];

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      pos_q <= '0;
      da_bcast_q <= 1'b0;
      da_mcast_q <= 1'b0;
      eval_q <= 1'b0;
      good_q <= 1'b0;
      da_q <= '0;
    end else begin
      eval_q <= rx_valid_in && rx_beat_in.eof;
      if (rx_valid_in) begin
        if (cur_pos != '1) begin
          pos_q <= cur_pos + 1'b1;
        end
        if (cur_pos == '0) begin
          da_mcast_q <= rx_beat_in.data[0];
          da_bcast_q <= (rx_beat_in.data == BCAST_BYTE);
        end else if (cur_pos < POS_W'(DA_LEN)) begin
          da_bcast_q <= da_bcast_q && (rx_beat_in.data == BCAST_BYTE);
        end
        if (rx_beat_in.eof) begin
          good_q <= rx_beat_in.good;
          da_q <= rx_da_in;
        end
      end
    end
  end

  // Per-set windows, running CRC and last masked byte.
  logic [POS_W-1:0] base [NUM_SETS];
  logic [15:0] run_crc_q [NUM_SETS];
  logic [7:0] run_last_q [NUM_SETS];
  logic [NUM_SETS-1:0] set_match;

  generate
    for (genvar g = 0; g < NUM_SETS; g++) begin : g_set
      logic [POS_W-1:0] rel;
      logic in_win;
      logic first;
      logic sel;
      logic chain_end;
      logic [15:0] seed_crc;
      logic [7:0] seed_last;
      logic [POS_W-1:0] own_base;

      assign own_base = POS_W'({off_q[g], 1'b0}); // [R5]
      if (g == 0) begin : g_head
        assign base[g] = own_base;
        assign seed_crc = CRC_INIT; // [R20]
        assign seed_last = 8'h00;
      end else begin : g_link
        assign base[g] = casc[g-1] ? base[g-1] + POS_W'(MASK_BITS)
                                   : own_base; // [R13] [R14]
        assign seed_crc = casc[g-1] ? run_crc_q[g-1] : CRC_INIT; // [R7]
        assign seed_last = casc[g-1] ? run_last_q[g-1] : 8'h00;
      end
      if (g == NUM_SETS - 1) begin : g_tail
        assign chain_end = 1'b1;
      end else begin : g_mid
        assign chain_end = !casc[g]; // [R13]
      end

      assign rel = cur_pos - base[g];
      assign in_win = (cur_pos >= base[g]) && (rel < POS_W'(MASK_BITS));
      assign first = in_win && (rel == '0);
      assign sel = mask_q[g][rel[4:0]]; // [R2]

      always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
          run_crc_q[g] <= CRC_INIT;
          run_last_q[g] <= 8'h00;
        end else if (rx_valid_in) begin
          if (first) begin
            run_crc_q[g] <= sel ? crc16_byte(seed_crc, rx_beat_in.data)
                                : seed_crc; // [R7]
            run_last_q[g] <= sel ? rx_beat_in.data : seed_last;
          end else if (in_win && sel) begin
            run_crc_q[g] <= crc16_byte(run_crc_q[g],
                                       rx_beat_in.data); // [R3] [R20]
            run_last_q[g] <= rx_beat_in.data; // [R6]
          end else if (rx_beat_in.sof) begin
            run_crc_q[g] <= CRC_INIT;
            run_last_q[g] <= 8'h00;
          end
        end
      end

      assign set_match[g] = chain_end && cmd_q[g][CMD_ENABLE] // [R9]
        && (run_crc_q[g] == crc_pat_q[g]) // [R3] [R4]
        && (run_last_q[g] == last_pat_q[g]) // [R4] [R6]
        && (!cmd_q[g][CMD_DA] || da_q.station_match) // [R10]
        && (!cmd_q[g][CMD_MCAST]
            || (da_mcast_q && da_q.hash_pass)) // [R11]
        && (!da_bcast_q || glob_q[GLB_BCAST_LSB + g]); // [R18]
    end
  endgenerate

  // Suspend synchroniser and mask wake timer.
  logic sus_m1_q;
  logic sus_m2_q;
  logic sus_m3_q;
  logic suspended_q;
  logic [31:0] sec_cnt_q;
  logic sec_tick;
  logic [5:0] mask_left_q;
  logic [3:0] tmr_code;
  logic [3:0] tmr_eff;

  assign tmr_code = glob_q[GLB_TIMER_LSB +: 4];
  assign tmr_eff = (tmr_code > TIMER_MAX_CODE) ? TIMER_MAX_CODE : tmr_code;
  assign sec_tick = (sec_cnt_q == 32'(SEC_CYC - 1));

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      sus_m1_q <= 1'b0;
      sus_m2_q <= 1'b0;
      sus_m3_q <= 1'b0;
      suspended_q <= 1'b0;
    end else begin
      sus_m1_q <= suspend_in;
      sus_m2_q <= sus_m1_q;
      sus_m3_q <= sus_m2_q;
      if (sus_m2_q == sus_m3_q) begin
        suspended_q <= sus_m3_q;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      sec_cnt_q <= 32'h0000_0000;
      mask_left_q <= 6'h00;
    end else if (!suspended_q && sus_m2_q == sus_m3_q && sus_m3_q) begin
      sec_cnt_q <= 32'h0000_0000;
      mask_left_q <= 6'(tmr_eff * MASK_STEP_S); // [R17]
    end else if (!suspended_q || mask_left_q == 6'h00) begin
      sec_cnt_q <= 32'h0000_0000;
      mask_left_q <= 6'h00;
    end else if (sec_tick) begin
      sec_cnt_q <= 32'h0000_0000;
      mask_left_q <= mask_left_q - 6'h01; // [R17]
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
    end
  end

  // Frame verdict, at the outputs two cycles after the last beat.
  logic wake_any;
  assign wake_any = good_q && ((|set_match)
    || (glob_q[GLB_DA_ONLY] && da_q.station_match) // [R15]
    || (glob_q[GLB_MC_ONLY] && da_mcast_q && da_q.hash_pass)); // [R16]

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      wake_frame_out <= 1'b0;
      wake_host_out <= 1'b0;
      match_sets_out <= 8'h00;
      reply_req_out <= 8'h00;
      mask_active_out <= 1'b0;
    end else begin
      mask_active_out <= suspended_q && (mask_left_q != 6'h00);
      wake_frame_out <= eval_q && wake_any;
      wake_host_out <= eval_q && wake_any && suspended_q
                       && (mask_left_q == 6'h00); // [R17]
      reply_req_out <= 8'h00;
      if (eval_q) begin
        match_sets_out <= good_q ? set_match : 8'h00; // [R1]
        for (int i = 0; i < NUM_SETS; i++) begin
          reply_req_out[i] <= good_q && set_match[i] && suspended_q
                              && cmd_q[i][CMD_REPLY]; // [R12]
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: design/wfpf_pkg.sv
`default_nettype none
package wfpf_pkg;
  localparam int unsigned NUM_SETS = 8;
  localparam int unsigned MASK_BITS = 32;
  localparam int unsigned POS_W = 11;
  localparam int unsigned BYTES_PER_WORD = 4;
  localparam int unsigned DA_LEN = 6;

  // Indexed filter array words.
  localparam logic [7:0] IDX_MASK_TOP = 8'h07;
  localparam logic [7:0] IDX_CRC_BASE = 8'h08;
  localparam logic [7:0] IDX_OFF_BASE = 8'h0C;
  localparam logic [7:0] IDX_LAST_BASE = 8'h0E;
  localparam logic [7:0] IDX_CMD = 8'h10;
  localparam logic [7:0] IDX_GLOBAL = 8'h11;

  // Command nibble fields.
  localparam int unsigned CMD_ENABLE = 0;
  localparam int unsigned CMD_DA = 1;
  localparam int unsigned CMD_MCAST = 2;
  localparam int unsigned CMD_REPLY = 3;

  // Global word fields.
  localparam int unsigned GLB_CASC_LSB = 0;
  localparam int unsigned GLB_DA_ONLY = 8;
  localparam int unsigned GLB_MC_ONLY = 9;
  localparam int unsigned GLB_TIMER_LSB = 16;
  localparam int unsigned GLB_BCAST_LSB = 24;
  localparam logic [31:0] GLB_RW_MASK = 32'hFF0F_037F;
  localparam logic [31:0] GLB_RESET = 32'h0000_0000;

  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [7:0] BCAST_BYTE = 8'hFF;

  // Mask timer: seconds per code step, highest defined code.
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MASK_STEP_S = 4;
  localparam int unsigned SEC_CYCLES = CLK_HZ * 1;
  localparam logic [3:0] TIMER_MAX_CODE = 4'h7;

  typedef enum logic [5:0] {
    WFPF_RG_MASK = 6'b00_0001,
    WFPF_RG_CRC = 6'b00_0010,
    WFPF_RG_OFF = 6'b00_0100,
    WFPF_RG_LAST = 6'b00_1000,
    WFPF_RG_CMD = 6'b01_0000,
    WFPF_RG_GLOB = 6'b10_0000
  } wfpf_region_t;

  typedef struct packed {
    logic sof;
    logic eof;
    logic good;
    logic [7:0] data;
  } wfpf_rx_beat_t;

  typedef struct packed {
    logic station_match;
    logic hash_pass;
  } wfpf_da_info_t;
endpackage
`default_nettype wire

// File: verif/wfpf_filter_properties.sv
`default_nettype none
module wfpf_checker import wfpf_pkg::*; #(
  parameter int unsigned SEC_CYC = SEC_CYCLES
) (
  input wire logic core_clk_in, // clock
  input wire logic rst_b_in, // reset
  input wire logic host_setup_valid_in, // setup
  input wire logic host_setup_write_in, // direction
  input wire logic [7:0] host_index_in, // index
  input wire logic host_byte_valid_in, // byte strobe
  input wire logic [7:0] host_byte_in, // byte
  input wire logic host_rd_valid_out, // read valid
  input wire logic [7:0] host_rd_byte_out, // read byte
  input wire logic rx_valid_in, // beat valid
  input wire wfpf_pkg::wfpf_rx_beat_t rx_beat_in, // beat
  input wire wfpf_pkg::wfpf_da_info_t rx_da_in, // address checks
  input wire logic suspend_in, // suspend
  input wire logic wake_frame_out, // wake frame
  input wire logic wake_host_out, // host wake
  input wire logic [7:0] match_sets_out, // matched sets
  input wire logic [7:0] reply_req_out, // reply request
  input wire logic mask_active_out // masked
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic eof_any;
  logic eof_good;
  assign eof_any = rx_valid_in && rx_beat_in.eof;
  assign eof_good = eof_any && rx_beat_in.good;
  a_rd_has_cause: assert property (host_rd_valid_out |->
    $past(host_byte_valid_in)) else $error("read byte without strobe");
  a_rd_byte_hold: assert property (!host_rd_valid_out |->
    $stable(host_rd_byte_out)) else $error("read byte moved");
  a_wake_has_frame: assert property (wake_frame_out |->
    $past(eof_good, 2)) else $error("wake without good frame end");
  a_bad_frame_clears: assert property (eof_any && !rx_beat_in.good |->
    ##2 match_sets_out == 8'h00 && !wake_frame_out)
    else $error("bad frame matched");
  a_match_sets_hold: assert property (!$past(eof_any, 2) |->
    $stable(match_sets_out)) else $error("match sets moved");
  a_reply_needs_match: assert property (
    (reply_req_out & ~match_sets_out) == 8'h00)
    else $error("reply without match");
  a_host_wake_unmasked: assert property (wake_host_out |->
    wake_frame_out && !mask_active_out) else $error("host wake masked");
  a_mask_needs_suspend: assert property (!suspend_in [*8] |->
    !mask_active_out) else $error("mask while awake");
  c_host_wake: cover property (wake_host_out);
  c_reply: cover property (reply_req_out != 8'h00);
  c_chain_end: cover property (match_sets_out == 8'h02);
endmodule
bind wfpf_filter wfpf_checker #(.SEC_CYC(SEC_CYC)) u_chk (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
  .host_setup_valid_in(host_setup_valid_in),
  .host_setup_write_in(host_setup_write_in), .host_index_in(host_index_in),
  .host_byte_valid_in(host_byte_valid_in), .host_byte_in(host_byte_in),
  .host_rd_valid_out(host_rd_valid_out), .host_rd_byte_out(host_rd_byte_out),
  .rx_valid_in(rx_valid_in), .rx_beat_in(rx_beat_in), .rx_da_in(rx_da_in),
  .suspend_in(suspend_in), .wake_frame_out(wake_frame_out),
  .wake_host_out(wake_host_out), .match_sets_out(match_sets_out),
  .reply_req_out(reply_req_out), .mask_active_out(mask_active_out));
`default_nettype wire

// File: verif/wfpf_mac_model.sv
`default_nettype none
module wfpf_mac_model import wfpf_pkg::*; (
  input wire logic core_clk_in, // clock
  input wire logic send_in, // start one frame
  input wire logic [319:0] frame_in, // 40 bytes, byte 0 lowest
  input wire logic good_in, // frame status
  input wire wfpf_pkg::wfpf_da_info_t da_in, // address checks
  output logic rx_valid_out, // beat valid
  output wfpf_pkg::wfpf_rx_beat_t rx_beat_out, // beat
  output wfpf_pkg::wfpf_da_info_t rx_da_out // address checks
);
  logic [5:0] cnt_q = 6'h28;
  logic live;
  assign live = cnt_q != 6'h28;
  always_ff @(posedge core_clk_in) begin
    if (send_in && !live) begin
      cnt_q <= 6'h00;
    end else if (live) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  // Idle lines carry inverted values so a stale byte never looks valid.
  always_comb begin
    rx_valid_out = live;
    rx_beat_out.sof = cnt_q == 6'h00;
    rx_beat_out.eof = cnt_q == 6'h27;
    rx_beat_out.good = rx_beat_out.eof ? good_in : ~good_in;
    rx_beat_out.data = live ? frame_in[{cnt_q, 3'h0} +: 8]
                            : ~frame_in[319:312];
    rx_da_out = rx_beat_out.eof ? da_in : ~da_in;
  end
endmodule
`default_nettype wire

// File: verif/wfpf_filter_bench.sv
`default_nettype none
module wfpf_filter_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import wfpf_pkg::*;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic sv = 1'h0;
  logic sw = 1'h0;
  logic bv = 1'h0;
  logic susp = 1'h0;
  logic send = 1'h0;
  logic good = 1'h1;
  logic [7:0] idx = 8'h00;
  logic [7:0] bd = 8'h00;
  logic [319:0] fr = 320'h0;
  wfpf_da_info_t da = 2'h0;
  logic rdv, wf, wh, ma, rxv, h_s;
  logic [7:0] rdb, ms, rr, r_s;
  wfpf_rx_beat_t rxb;
  wfpf_da_info_t rxd;
  int error_cnt = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  wfpf_filter #(.SEC_CYC(20)) DUT (.core_clk_in(clk), .rst_b_in(rst_b),
    .host_setup_valid_in(sv), .host_setup_write_in(sw), .host_index_in(idx),
    .host_byte_valid_in(bv), .host_byte_in(bd), .host_rd_valid_out(rdv),
    .host_rd_byte_out(rdb), .rx_valid_in(rxv), .rx_beat_in(rxb),
    .rx_da_in(rxd), .suspend_in(susp), .wake_frame_out(wf),
    .wake_host_out(wh), .match_sets_out(ms), .reply_req_out(rr),
    .mask_active_out(ma));
  wfpf_mac_model u_mac (.core_clk_in(clk), .send_in(send), .frame_in(fr),
    .good_in(good), .da_in(da), .rx_valid_out(rxv), .rx_beat_out(rxb),
    .rx_da_out(rxd));
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] crc(input logic [15:0] c,
                                      input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    {sv, sw, idx} <= {2'h3, a};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {sv, bv, bd} <= {2'h1, w[8*i+:8]};
    end
    @(posedge clk);
    bv <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] w);
    @(posedge clk);
    {sv, sw, idx} <= {2'h2, a};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {sv, bv} <= 2'h1;
      @(posedge clk);
      bv <= 1'h0;
      #1;
      chk(rdv, 1'h1);
      w[8*i+:8] = rdb;
    end
  endtask
  // An unknown expected set mask skips that comparison.
  task automatic fx(input logic g, input logic st, input logic hp,
                    input logic [7:0] em, input logic ef);
    @(posedge clk);
    {send, good, da} <= {1'h1, g, st, hp};
    @(posedge clk);
    send <= 1'h0;
    do @(posedge clk); while (!(rxv === 1'h1 && rxb.eof === 1'h1));
    // The verdict pulses stand for the one cycle after the next edge.
    @(posedge clk);
    #1;
    h_s = wh;
    r_s = rr;
    if (!$isunknown(em)) chk(ms, em);
    chk(wf, ef);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
  initial begin
    logic [31:0] w;
    logic [15:0] c;
    for (int i = 0; i < 40; i++) fr[8*i+:8] = 8'h10 + 8'(i);
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    #1 chk({rr, ms, wf, wh, ma, rdv}, 32'h0000_0000);
    rd(8'h11, w);
    chk(w, GLB_RESET);
    wr(8'h11, 32'hFFFF_FFFF);
    rd(8'h11, w);
    chk(w, GLB_RW_MASK);
    wr(8'h0D, 32'h4433_2211);
    rd(8'h0D, w);
    chk(w, 32'h4433_2211);
    wr(8'h12, 32'hFFFF_FFFF);
    rd(8'h12, w);
    chk(w, 32'h0000_0000);
    wr(8'h11, 32'h0000_0000);
    c = crc(crc(crc(CRC_INIT, fr[16+:8]), fr[40+:8]), fr[48+:8]);
    wr(8'h00, 32'h0000_0019);
    wr(8'h08, {16'h0000, c});
    wr(8'h0C, 32'h0000_0001);
    wr(8'h0E, 32'h0000_0016);
    wr(8'h10, 32'h0000_0001);
    fx(1'h1, 1'h0, 1'h0, 8'h01, 1'h1);
    wr(8'h0E, 32'h0000_0017);
    fx(1'h1, 1'h0, 1'h0, 8'h00, 1'h0);
    wr(8'h0E, 32'h0000_0016);
    wr(8'h0C, 32'h0000_0000);
    fx(1'h1, 1'h0, 1'h0, 8'h00, 1'h0);
    wr(8'h0C, 32'h0000_0001);
    fx(1'h0, 1'h0, 1'h0, 8'h00, 1'h0);
    wr(8'h10, 32'h0000_0000);
    fx(1'h1, 1'h0, 1'h0, 8'h00, 1'h0);
    wr(8'h10, 32'h0000_0003);
    fx(1'h1, 1'h0, 1'h0, 8'hxx, 1'h0);
    fx(1'h1, 1'h1, 1'h0, 8'h01, 1'h1);
    wr(8'h10, 32'h0000_0005);
    fx(1'h1, 1'h0, 1'h1, 8'hxx, 1'h0);
    wr(8'h10, 32'h0000_0009);
    wr(8'h11, 32'h0001_0000);
    @(posedge clk);
    susp <= 1'h1;
    repeat (10) @(posedge clk);
    #1 chk(ma, 1'h1);
    fx(1'h1, 1'h0, 1'h0, 8'h01, 1'h1);
    chk(h_s, 1'h0);
    chk(r_s, 8'h01);
    repeat (60) @(posedge clk);
    #1 chk(ma, 1'h0);
    fx(1'h1, 1'h0, 1'h0, 8'h01, 1'h1);
    chk(h_s, 1'h1);
    wr(8'h10, 32'h0000_0001);
    fx(1'h1, 1'h0, 1'h0, 8'h01, 1'h1);
    chk(r_s, 8'h00);
    @(posedge clk);
    susp <= 1'h0;
    wr(8'h10, 32'h0000_0000);
    wr(8'h11, 32'h0000_0100);
    fx(1'h1, 1'h1, 1'h0, 8'hxx, 1'h1);
    fx(1'h1, 1'h0, 1'h0, 8'hxx, 1'h0);
    wr(8'h11, 32'h0000_0000);
    c = crc(crc(CRC_INIT, fr[16+:8]), fr[264+:8]);
    wr(8'h00, 32'h0000_0004);
    wr(8'h01, 32'h0000_0002);
    wr(8'h08, {c, 16'h0000});
    wr(8'h0C, 32'h0000_0000);
    wr(8'h0E, {16'h0000, fr[264+:8], 8'h00});
    wr(8'h10, 32'h0000_0010);
    fx(1'h1, 1'h0, 1'h0, 8'h00, 1'h0);
    wr(8'h11, 32'h0000_0001);
    fx(1'h1, 1'h0, 1'h0, 8'h02, 1'h1);
    // Broadcast destination, which is also a multicast destination.
    for (int i = 0; i < 6; i++) fr[8*i+:8] = BCAST_BYTE;
    c = crc(crc(crc(CRC_INIT, fr[16+:8]), fr[40+:8]), fr[48+:8]);
    wr(8'h11, 32'h0000_0000);
    wr(8'h00, 32'h0000_0019);
    wr(8'h08, {16'h0000, c});
    wr(8'h0C, 32'h0000_0001);
    wr(8'h0E, 32'h0000_0016);
    wr(8'h10, 32'h0000_0005);
    fx(1'h1, 1'h0, 1'h1, 8'h00, 1'h0);
    wr(8'h11, 32'h0100_0000);
    fx(1'h1, 1'h0, 1'h1, 8'h01, 1'h1);
    fx(1'h1, 1'h0, 1'h0, 8'h00, 1'h0);
    wr(8'h10, 32'h0000_0000);
    wr(8'h11, 32'h0000_0200);
    fx(1'h1, 1'h0, 1'h1, 8'h00, 1'h1);
    fx(1'h1, 1'h0, 1'h0, 8'h00, 1'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
